// ===== rtl/eag_agu.sv
// effective address generator with x and y circular buffer correction
// assumes decoder presents one request per cycle with pointer values already read;
// apb master on the same clock; results appear one cycle after the request
//
// Operation
// - file register mode uses 13-bit direct address into lowest 8192 bytes
// - first source of three-operand instructions is always register direct
// - second source is working register, memory or 5-bit literal
// - post-modify issues pointer then steps it by a constant
// - pre-modify adds signed constant first and issues the result
// - indexed address is pointer plus base offset register
// - literal offset address is pointer plus instruction literal
// - move source and destination share one 4-bit offset field
// - prefetch pointers limited to registers 8..11; 8,9 x, 10,11 y
// - prefetch indexed only on register 9 in x and 11 in y
// - prefetch supports indirect, indexed, and post-modify by 2, 4, 6
// - one circular buffer in x space and an independent one in y
// - power-of-two buffers check both boundaries, working bidirectionally
// - each buffer bounded by 16-bit start and end registers
// - buffer lengths up to 32K words, 64 Kbytes, are handled
// - pointer select of 15 disables circular correction for that space
// - x correction only for pointer in bits 3:0 with bit 15 set
// - y correction only for pointer in bits 7:4 with bit 14 set
// - correction triggers only past the boundary in the travel direction, or past either one for power-of-two buffers, not on it
// - corrected value written back only in pre or post modify modes
// - y circular addresses always have bit 0 cleared
`timescale 1ns/10ps
module eag_agu (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_REQ_VALID,
  input  wire logic [2:0]  I_REQ_MODE,
  input  wire logic [1:0]  I_REQ_SPACE,
  input  wire logic        I_REQ_MAC,
  input  wire logic [1:0]  I_REQ_MAC_STEP,
  input  wire logic        I_REQ_MAC_DEC,
  input  wire logic [3:0]  I_REQ_PTR_SEL,
  input  wire logic [15:0] I_REQ_PTR_VAL,
  input  wire logic [3:0]  I_REQ_BASE_SEL,
  input  wire logic [15:0] I_REQ_OFFSET_VAL,
  input  wire logic        I_REQ_MOV_DST,
  input  wire logic [15:0] I_REQ_STEP,
  input  wire logic [9:0]  I_REQ_LIT,
  input  wire logic [12:0] I_REQ_FADDR,
  output logic             O_ADDR_VALID,
  output logic      [15:0] O_ADDR,
  output logic      [1:0]  O_ADDR_SPACE,
  output logic      [1:0]  O_SRC_KIND,
  output logic      [15:0] O_LIT_VAL,
  output logic      [3:0]  O_BASE_SEL,
  output logic             O_WB_EN,
  output logic      [3:0]  O_WB_SEL,
  output logic      [15:0] O_WB_DATA,
  output logic             O_ERR,
  output logic             O_WRAPPED
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] xs;
    logic [15:0] xe;
    logic [15:0] ys;
    logic [15:0] ye;
    logic [15:0] off_keep;
    logic        addr_vld;
    logic [15:0] addr;
    logic [1:0]  space;
    logic [1:0]  kind;
    logic [15:0] lit;
    logic [3:0]  base_sel;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_data;
    logic        err;
    logic        wrapped;
  } eag_state_s;

  eag_state_s st_ff;
  eag_state_s nxt_st;

  // buffer length in bytes, 18 bits so a full 64 Kbyte span fits
  function automatic logic [17:0] eag_len(input logic [15:0] lo, input logic [15:0] hi);
    return {2'b00, hi} - {2'b00, lo} + 18'h0_0001;
  endfunction

  function automatic logic eag_pow2(input logic [17:0] len);
    return (len != 18'h0_0000) && ((len & (len - 18'h0_0001)) == 18'h0_0000);
  endfunction

  // returns {wrapped, corrected address}; sum is signed 18-bit
  function automatic logic [16:0] eag_wrap(input logic [17:0] sum, input logic [15:0] lo,
                                           input logic [15:0] hi, input logic dec, input logic both);
    logic [17:0] len;
    logic [17:0] res;
    logic        w;
    len = eag_len(lo, hi);
    res = sum;
    w   = 1'b0;
    if ((!dec || both) && ($signed(sum) > $signed({2'b00, hi}))) begin
      res = sum - len;
      w   = 1'b1;
    end else if ((dec || both) && ($signed(sum) < $signed({2'b00, lo}))) begin
      res = sum + len;
      w   = 1'b1;
    end
    return {w, res[15:0]};
  endfunction

  function automatic logic [17:0] eag_sext16(input logic [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  // request datapath
  logic        mac_ptr_ok;
  logic        mac_mode_ok;
  logic        mac_bad;
  logic [1:0]  space_eff;
  logic [15:0] mac_mag;
  logic [15:0] step;
  logic [15:0] off_val;
  logic [15:0] litoff;
  logic [17:0] raw_sum;
  logic        dir_dec;
  logic [3:0]  xsel;
  logic [3:0]  ysel;
  logic        x_on;
  logic        y_on;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [16:0] wr;
  logic        mod_on;
  logic [15:0] new_val;
  logic [15:0] ptr_out;
  logic [7:0]  waddr;
  logic        apb_wr;
  logic        apb_hit;

  assign mac_ptr_ok  = (I_REQ_PTR_SEL >= eag_pkg::MAC_X_LO) && (I_REQ_PTR_SEL <= eag_pkg::MAC_Y_HI);
  assign mac_mode_ok = (I_REQ_MODE == eag_pkg::M_IND)
                    || (I_REQ_MODE == eag_pkg::M_POST && I_REQ_MAC_STEP != eag_pkg::MAC_STEP_NONE)
                    || (I_REQ_MODE == eag_pkg::M_IDX
                        && (I_REQ_PTR_SEL == eag_pkg::MAC_X_HI || I_REQ_PTR_SEL == eag_pkg::MAC_Y_HI));
  assign mac_bad     = I_REQ_MAC && !(mac_ptr_ok && mac_mode_ok);
  assign space_eff   = !I_REQ_MAC ? I_REQ_SPACE
                     : (I_REQ_PTR_SEL <= eag_pkg::MAC_X_HI) ? eag_pkg::SP_XRD : eag_pkg::SP_Y;

  // prefetch step of 2, 4 or 6 bytes
  assign mac_mag = {13'h0000, I_REQ_MAC_STEP, 1'b0};
  assign step    = !I_REQ_MAC ? I_REQ_STEP : (I_REQ_MAC_DEC ? (16'h0000 - mac_mag) : mac_mag);

  // a move destination reuses the offset latched with its source
  assign off_val = I_REQ_MOV_DST ? st_ff.off_keep : I_REQ_OFFSET_VAL;
  assign litoff  = {{6{I_REQ_LIT[9]}}, I_REQ_LIT};

  always_comb begin
    case (I_REQ_MODE)
      eag_pkg::M_IDX: begin
        raw_sum = {2'b00, I_REQ_PTR_VAL} + eag_sext16(off_val);
        dir_dec = off_val[15];
      end
      eag_pkg::M_LITOFF: begin
        raw_sum = {2'b00, I_REQ_PTR_VAL} + eag_sext16(litoff);
        dir_dec = litoff[15];
      end
      default: begin
        raw_sum = {2'b00, I_REQ_PTR_VAL} + eag_sext16(step);
        dir_dec = step[15];
      end
    endcase
  end

  assign xsel = st_ff.ctrl[eag_pkg::CTRL_XSEL_LSB +: 4];
  assign ysel = st_ff.ctrl[eag_pkg::CTRL_YSEL_LSB +: 4];
  assign x_on = st_ff.ctrl[eag_pkg::CTRL_XEN_BIT] && (xsel != eag_pkg::SEL_OFF)
             && (I_REQ_PTR_SEL == xsel) && (space_eff != eag_pkg::SP_Y);
  assign y_on = st_ff.ctrl[eag_pkg::CTRL_YEN_BIT] && (ysel != eag_pkg::SEL_OFF)
             && (I_REQ_PTR_SEL == ysel) && (space_eff == eag_pkg::SP_Y);

  // x bounds serve both x generators, read and write
  assign lo = (space_eff == eag_pkg::SP_Y) ? st_ff.ys : st_ff.xs;
  assign hi = (space_eff == eag_pkg::SP_Y) ? st_ff.ye : st_ff.xe;
  assign wr = eag_wrap(raw_sum, lo, hi, dir_dec, eag_pow2(eag_len(lo, hi)));

  assign mod_on  = (x_on || y_on) && (I_REQ_MODE == eag_pkg::M_POST || I_REQ_MODE == eag_pkg::M_PRE
                 || I_REQ_MODE == eag_pkg::M_IDX || I_REQ_MODE == eag_pkg::M_LITOFF);
  assign new_val = mod_on ? {wr[15:1], wr[0] & ~y_on} : raw_sum[15:0];
  assign ptr_out = {I_REQ_PTR_VAL[15:1], I_REQ_PTR_VAL[0] & ~y_on};

  // apb slave, zero wait states
  assign waddr   = I_PADDR;
  assign apb_hit = (waddr == eag_pkg::REG_CTRL) || (waddr == eag_pkg::REG_XSTART)
                || (waddr == eag_pkg::REG_XEND) || (waddr == eag_pkg::REG_YSTART)
                || (waddr == eag_pkg::REG_YEND) || (waddr == eag_pkg::REG_STATUS);
  assign apb_wr  = I_PSEL && I_PENABLE && I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !apb_hit;

  always_comb begin
    case (waddr)
      eag_pkg::REG_CTRL:   O_PRDATA = {16'h0000, st_ff.ctrl};
      eag_pkg::REG_XSTART: O_PRDATA = {16'h0000, st_ff.xs};
      eag_pkg::REG_XEND:   O_PRDATA = {16'h0000, st_ff.xe};
      eag_pkg::REG_YSTART: O_PRDATA = {16'h0000, st_ff.ys};
      eag_pkg::REG_YEND:   O_PRDATA = {16'h0000, st_ff.ye};
      eag_pkg::REG_STATUS: O_PRDATA = {st_ff.addr, 14'h0000, st_ff.wrapped, st_ff.err};
      default:             O_PRDATA = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.addr_vld = 1'b0;
    nxt_st.wb_en    = 1'b0;
    nxt_st.err      = 1'b0;
    nxt_st.wrapped  = 1'b0;
    if (apb_wr) begin
      case (waddr)
        eag_pkg::REG_CTRL:   nxt_st.ctrl = I_PWDATA[15:0] & eag_pkg::CTRL_MASK;
        eag_pkg::REG_XSTART: nxt_st.xs   = I_PWDATA[15:0];
        eag_pkg::REG_XEND:   nxt_st.xe   = I_PWDATA[15:0];
        eag_pkg::REG_YSTART: nxt_st.ys   = I_PWDATA[15:0];
        eag_pkg::REG_YEND:   nxt_st.ye   = I_PWDATA[15:0];
        default:             nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    if (I_REQ_VALID) begin
      nxt_st.space    = space_eff;
      nxt_st.base_sel = I_REQ_BASE_SEL;
      nxt_st.wb_sel   = I_REQ_PTR_SEL;
      nxt_st.kind     = eag_pkg::K_MEM;
      nxt_st.lit      = 16'h0000;
      if (!I_REQ_MOV_DST) begin
        nxt_st.off_keep = I_REQ_OFFSET_VAL;
      end
      case (I_REQ_MODE)
        eag_pkg::M_FILE: begin
          nxt_st.addr_vld = 1'b1;
          nxt_st.addr     = {3'b000, I_REQ_FADDR};
        end
        eag_pkg::M_REGDIR: begin
          nxt_st.kind = eag_pkg::K_DEFAULT_WORKING_REGISTER;
        end
        eag_pkg::M_LIT5: begin
          nxt_st.kind = eag_pkg::K_LIT;
          nxt_st.lit  = {11'h000, I_REQ_LIT[eag_pkg::LIT5_W-1:0]};
        end
        eag_pkg::M_IND: begin
          nxt_st.addr_vld = 1'b1;
          nxt_st.addr     = ptr_out;
        end
        eag_pkg::M_POST: begin
          nxt_st.addr_vld = 1'b1;
          nxt_st.addr     = ptr_out;
          nxt_st.wb_en    = 1'b1;
          nxt_st.wb_data  = new_val;
          nxt_st.wrapped  = mod_on && wr[16];
        end
        eag_pkg::M_PRE: begin
          nxt_st.addr_vld = 1'b1;
          nxt_st.addr     = new_val;
          nxt_st.wb_en    = 1'b1;
          nxt_st.wb_data  = new_val;
          nxt_st.wrapped  = mod_on && wr[16];
        end
        default: begin
          // indexed and literal offset: pointer left untouched
          nxt_st.addr_vld = 1'b1;
          nxt_st.addr     = new_val;
          nxt_st.wrapped  = mod_on && wr[16];
        end
      endcase
      if (mac_bad) begin
        nxt_st.addr_vld = 1'b0;
        nxt_st.wb_en    = 1'b0;
        nxt_st.wrapped  = 1'b0;
        nxt_st.err      = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_ff          <= '0;
      st_ff.ctrl     <= eag_pkg::CTRL_RST;
      st_ff.xs       <= eag_pkg::BOUND_RST;
      st_ff.xe       <= eag_pkg::BOUND_RST;
      st_ff.ys       <= eag_pkg::BOUND_RST;
      st_ff.ye       <= eag_pkg::BOUND_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_ADDR_VALID = st_ff.addr_vld;
  assign O_ADDR       = st_ff.addr;
  assign O_ADDR_SPACE = st_ff.space;
  assign O_SRC_KIND   = st_ff.kind;
  assign O_LIT_VAL    = st_ff.lit;
  assign O_BASE_SEL   = st_ff.base_sel;
  assign O_WB_EN      = st_ff.wb_en;
  assign O_WB_SEL     = st_ff.wb_sel;
  assign O_WB_DATA    = st_ff.wb_data;
  assign O_ERR        = st_ff.err;
  assign O_WRAPPED    = st_ff.wrapped;

  // checks; the x/y enables of zero make the datapath plain
  a_file_direct: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && I_REQ_MODE == eag_pkg::M_FILE)
    |=> (O_ADDR_VALID && O_ADDR == {3'b000, $past(I_REQ_FADDR)}))
    else $error("file register address wrong");

  a_post_issue: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && !I_REQ_MAC && I_REQ_MODE == eag_pkg::M_POST && !y_on)
    |=> (O_ADDR == $past(I_REQ_PTR_VAL) && O_WB_EN && O_WB_SEL == $past(I_REQ_PTR_SEL)))
    else $error("post-modify did not issue old pointer");

  a_pre_issue: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && !I_REQ_MAC && I_REQ_MODE == eag_pkg::M_PRE)
    |=> (O_WB_EN && O_WB_DATA == O_ADDR
         && ($past(x_on) || $past(y_on) || O_ADDR == 16'($past(I_REQ_PTR_VAL) + $past(I_REQ_STEP)))))
    else $error("pre-modify address differs from written pointer");

  a_index_sum: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && !I_REQ_MAC && !I_REQ_MOV_DST && I_REQ_MODE == eag_pkg::M_IDX && !x_on && !y_on)
    |=> (O_ADDR == 16'($past(I_REQ_PTR_VAL) + $past(I_REQ_OFFSET_VAL))))
    else $error("indexed address is not pointer plus offset");

  a_offset_keeps: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && (I_REQ_MODE == eag_pkg::M_IDX || I_REQ_MODE == eag_pkg::M_LITOFF))
    |=> !O_WB_EN)
    else $error("offset mode wrote the pointer back");

  a_mac_ptr_set: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && I_REQ_MAC && (I_REQ_PTR_SEL < eag_pkg::MAC_X_LO || I_REQ_PTR_SEL > eag_pkg::MAC_Y_HI))
    |=> (O_ERR && !O_ADDR_VALID && !O_WB_EN))
    else $error("prefetch pointer outside set accepted");

  a_mac_index: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && I_REQ_MAC && I_REQ_MODE == eag_pkg::M_IDX
     && (I_REQ_PTR_SEL == eag_pkg::MAC_X_LO || I_REQ_PTR_SEL == eag_pkg::MAC_Y_LO))
    |=> O_ERR)
    else $error("prefetch indexed on wrong pointer accepted");

  a_y_align: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && y_on && !mac_bad && I_REQ_MODE != eag_pkg::M_FILE
     && I_REQ_MODE != eag_pkg::M_REGDIR && I_REQ_MODE != eag_pkg::M_LIT5)
    |=> (O_ADDR[0] == 1'b0 && O_ADDR_SPACE == eag_pkg::SP_Y))
    else $error("y circular address not word aligned");

  a_sel_off: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && xsel == eag_pkg::SEL_OFF && space_eff != eag_pkg::SP_Y) |=> !O_WRAPPED)
    else $error("x correction with select 15");

  a_wrap_inside: assert property (
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (I_REQ_VALID && x_on && !mac_bad && I_REQ_MODE == eag_pkg::M_PRE
     && $signed(raw_sum) > $signed({2'b00, st_ff.xe})
     && 18'($signed(raw_sum) - $signed({2'b00, st_ff.xe})) <= eag_len(st_ff.xs, st_ff.xe))
    |=> (O_WRAPPED && O_ADDR >= $past(st_ff.xs) && O_ADDR <= $past(st_ff.xe)))
    else $error("wrapped address left the buffer");

endmodule

// ===== rtl/eag_pkg.sv
// effective address generator package: register map, control fields, modes, operand kinds
// assumes a 32-bit apb slave with word-aligned registers on the core clock
package eag_pkg;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_XSTART = 8'h04;
  localparam logic [7:0] REG_XEND   = 8'h08;
  localparam logic [7:0] REG_YSTART = 8'h0C;
  localparam logic [7:0] REG_YEND   = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // circular_buffer_control fields
  localparam int unsigned  CTRL_XSEL_LSB = 0;
  localparam int unsigned  CTRL_YSEL_LSB = 4;
  localparam int unsigned  CTRL_YEN_BIT  = 14;
  localparam int unsigned  CTRL_XEN_BIT  = 15;
  localparam logic [15:0]  CTRL_MASK     = 16'hC0FF;
  localparam logic [15:0]  CTRL_RST      = 16'h00FF;
  localparam logic [15:0]  BOUND_RST     = 16'h0000;
  localparam logic [3:0]   SEL_OFF       = 4'hF;

  // status word fields
  localparam int unsigned  STAT_ERR_BIT  = 0;
  localparam int unsigned  STAT_WRAP_BIT = 1;
  localparam int unsigned  STAT_ADDR_LSB = 16;

  // field widths
  localparam int unsigned  FADDR_W  = 13;
  localparam int unsigned  LIT5_W   = 5;
  localparam int unsigned  LITOFF_W = 10;

  // addressing modes
  localparam logic [2:0] M_FILE   = 3'h0;
  localparam logic [2:0] M_REGDIR = 3'h1;
  localparam logic [2:0] M_IND    = 3'h2;
  localparam logic [2:0] M_POST   = 3'h3;
  localparam logic [2:0] M_PRE    = 3'h4;
  localparam logic [2:0] M_IDX    = 3'h5;
  localparam logic [2:0] M_LITOFF = 3'h6;
  localparam logic [2:0] M_LIT5   = 3'h7;

  // address generators
  localparam logic [1:0] SP_XRD = 2'h0;
  localparam logic [1:0] SP_XWR = 2'h1;
  localparam logic [1:0] SP_Y   = 2'h2;

  // operand kinds
  localparam logic [1:0] K_DEFAULT_WORKING_REGISTER = 2'h0;
  localparam logic [1:0] K_MEM  = 2'h1;
  localparam logic [1:0] K_LIT  = 2'h2;

  // dual-operand prefetch pointer set
  localparam logic [3:0] MAC_X_LO = 4'h8;
  localparam logic [3:0] MAC_X_HI = 4'h9;
  localparam logic [3:0] MAC_Y_LO = 4'hA;
  localparam logic [3:0] MAC_Y_HI = 4'hB;
  localparam logic [1:0] MAC_STEP_NONE = 2'h0;

endpackage

// ===== tb/eag_dec_model.sv
// decoder-side driver: presents one address request per call
// assumes eag_agu takes a request at the edge where valid is high
`timescale 1ns/10ps
module eag_dec_model (
  input  wire logic   i_clk,
  output logic        o_valid,
  output logic [2:0]  o_mode,
  output logic [1:0]  o_space,
  output logic        o_mac,
  output logic [1:0]  o_mstep,
  output logic        o_mdec,
  output logic [3:0]  o_psel,
  output logic [15:0] o_pval,
  output logic [3:0]  o_base,
  output logic [15:0] o_off,
  output logic        o_movdst,
  output logic [15:0] o_step,
  output logic [9:0]  o_lit,
  output logic [12:0] o_faddr
);
  logic       mac = 1'b0;
  logic [1:0] mstep = 2'h0;
  logic       mdec = 1'b0;
  logic       movdst = 1'b0;
  initial {o_valid, o_mode, o_space, o_mac, o_mstep, o_mdec, o_psel, o_pval, o_base, o_off, o_movdst, o_step,
           o_lit, o_faddr} = '0;
  // one argument feeds step, offset, literal and file address; the mode picks which counts
  task automatic send(input logic [2:0] m, input logic [1:0] sp, input logic [3:0] p,
                      input logic [15:0] pv, input logic [15:0] a);
    @(posedge i_clk);
    o_valid  <= 1'b1;
    o_mode   <= m;
    o_space  <= sp;
    o_mac    <= mac;
    o_mstep  <= mstep;
    o_mdec   <= mdec;
    o_psel   <= p;
    o_pval   <= pv;
    o_base   <= a[3:0];
    o_off    <= a;
    o_movdst <= movdst;
    o_step   <= a;
    o_lit    <= a[9:0];
    o_faddr  <= a[12:0];
    @(posedge i_clk);
    o_valid  <= 1'b0;
    // released pointer, offset and step fields flip so a stale value never passes for a live one
    o_pval   <= ~pv;
    o_off    <= ~a;
    o_step   <= ~a;
    #1;
  endtask
endmodule

// ===== tb/eag_agu_bench.sv
// self-checking bench for eag_agu: apb register access and address requests
// assumes the decoder model and the apb master share the core clock
`timescale 1ns/10ps
module eag_agu_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, se;
  logic        valid, mac, mdec, movdst, av, wbe, err, wrp;
  logic [2:0]  mode;
  logic [1:0]  space, mstep, asp, kind;
  logic [3:0]  ps, base, bsel, wbs;
  logic [15:0] pval, off, step, addr, litv, wbd;
  logic [9:0]  lit;
  logic [12:0] faddr;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;

  eag_agu u_eag_agu (
    .I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_REQ_VALID(valid), .I_REQ_MODE(mode), .I_REQ_SPACE(space), .I_REQ_MAC(mac), .I_REQ_MAC_STEP(mstep),
    .I_REQ_MAC_DEC(mdec), .I_REQ_PTR_SEL(ps), .I_REQ_PTR_VAL(pval), .I_REQ_BASE_SEL(base),
    .I_REQ_OFFSET_VAL(off), .I_REQ_MOV_DST(movdst), .I_REQ_STEP(step), .I_REQ_LIT(lit),
    .I_REQ_FADDR(faddr), .O_ADDR_VALID(av), .O_ADDR(addr), .O_ADDR_SPACE(asp), .O_SRC_KIND(kind),
    .O_LIT_VAL(litv), .O_BASE_SEL(bsel), .O_WB_EN(wbe), .O_WB_SEL(wbs), .O_WB_DATA(wbd),
    .O_ERR(err), .O_WRAPPED(wrp)
  );
  eag_dec_model u_dec (
    .i_clk(clk), .o_valid(valid), .o_mode(mode), .o_space(space), .o_mac(mac), .o_mstep(mstep),
    .o_mdec(mdec), .o_psel(ps), .o_pval(pval), .o_base(base), .o_off(off), .o_movdst(movdst),
    .o_step(step), .o_lit(lit), .o_faddr(faddr)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_word(nm, 32'(e), 32'(g));
  endtask

  // zero-wait slave today, but the wait loop keeps the master honest
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready ends this wait; if it never comes, only the bench timeout ends the hang, and that reports a failure
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk_word("prdata", e, rd);
    chk_flag("pslverr", ee, se);
  endtask

  // one request, then its single-cycle answer
  task automatic tx(input logic [2:0] m, input logic [1:0] sp, input logic [3:0] p, input logic [15:0] pv,
                    input logic [15:0] a, input logic [15:0] ea, input logic we, input logic [15:0] wd,
                    input logic wr, input logic er);
    u_dec.send(m, sp, p, pv, a);
    chk_flag("err", er, err);
    chk_flag("addr_valid", ~er, av);
    chk_flag("wb_en", we, wbe);
    chk_flag("wrapped", wr, wrp);
    if (!er) chk_word("addr", 32'(ea), 32'(addr));
    if (we) chk_word("wb_data", 32'(wd), 32'(wbd));
    if (we) chk_word("wb_sel", 32'(p), 32'(wbs));
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(eag_pkg::REG_CTRL, 32'h0000_00FF, 1'b0);
    rd_chk(eag_pkg::REG_YEND, 32'h0000_0000, 1'b0);
    rd_chk(8'h18, 32'h0000_0000, 1'b1);
    apb(1'b1, eag_pkg::REG_CTRL, 32'hFFFF_FFFF);
    rd_chk(eag_pkg::REG_CTRL, 32'h0000_C0FF, 1'b0);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_00FF);
    tx(eag_pkg::M_FILE, 2'h0, 4'h0, 16'h5555, 16'h1FFF, 16'h1FFF, 0, 0, 0, 0);
    u_dec.send(eag_pkg::M_REGDIR, 2'h0, 4'h3, 16'h1234, 16'h0006);
    chk_word("src_kind", 32'(eag_pkg::K_DEFAULT_WORKING_REGISTER), 32'(kind));
    chk_word("base_sel", 32'h0000_0006, 32'(bsel));
    u_dec.send(eag_pkg::M_LIT5, 2'h0, 4'h3, 16'h1234, 16'h0015);
    chk_word("src_kind", 32'(eag_pkg::K_LIT), 32'(kind));
    chk_word("lit_val", 32'h0000_0015, 32'(litv));
    tx(eag_pkg::M_IND, 2'h0, 4'h1, 16'h0A00, 16'h0000, 16'h0A00, 0, 0, 0, 0);
    chk_word("src_kind", 32'(eag_pkg::K_MEM), 32'(kind));
    tx(eag_pkg::M_POST, 2'h0, 4'h1, 16'h0800, 16'h0002, 16'h0800, 1, 16'h0802, 0, 0);
    tx(eag_pkg::M_PRE, 2'h1, 4'h1, 16'h0800, 16'hFFFE, 16'h07FE, 1, 16'h07FE, 0, 0);
    tx(eag_pkg::M_IDX, 2'h0, 4'h1, 16'h1000, 16'h0010, 16'h1010, 0, 0, 0, 0);
    tx(eag_pkg::M_LITOFF, 2'h0, 4'h1, 16'h1000, 16'h03FE, 16'h0FFE, 0, 0, 0, 0);
    tx(eag_pkg::M_IDX, 2'h0, 4'h1, 16'h1000, 16'h0020, 16'h1020, 0, 0, 0, 0);
    u_dec.movdst = 1'b1;
    tx(eag_pkg::M_IDX, 2'h1, 4'h4, 16'h2000, 16'h0999, 16'h2020, 0, 0, 0, 0);
    u_dec.movdst = 1'b0;
    u_dec.mac = 1'b1;
    tx(eag_pkg::M_IND, 2'h2, 4'h8, 16'h0900, 16'h0000, 16'h0900, 0, 0, 0, 0);
    chk_word("space", 32'(eag_pkg::SP_XRD), 32'(asp));
    tx(eag_pkg::M_IND, 2'h0, 4'hA, 16'h0A00, 16'h0000, 16'h0A00, 0, 0, 0, 0);
    chk_word("space", 32'(eag_pkg::SP_Y), 32'(asp));
    tx(eag_pkg::M_IND, 2'h0, 4'h7, 16'h0A00, 16'h0000, 0, 0, 0, 0, 1);
    tx(eag_pkg::M_IDX, 2'h0, 4'h8, 16'h0900, 16'h0004, 0, 0, 0, 0, 1);
    tx(eag_pkg::M_IDX, 2'h0, 4'hB, 16'h0B00, 16'h0004, 16'h0B04, 0, 0, 0, 0);
    tx(eag_pkg::M_PRE, 2'h0, 4'h9, 16'h0900, 16'h0002, 0, 0, 0, 0, 1);
    tx(eag_pkg::M_POST, 2'h0, 4'h9, 16'h0900, 16'h0000, 0, 0, 0, 0, 1);
    for (int s = 1; s < 4; s++) begin
      u_dec.mstep = 2'(s);
      tx(eag_pkg::M_POST, 2'h0, 4'h9, 16'h0900, 16'h0000, 16'h0900, 1, 16'(16'h0900 + 2 * s), 0, 0);
    end
    u_dec.mdec = 1'b1;
    tx(eag_pkg::M_POST, 2'h0, 4'hB, 16'h0900, 16'h0000, 16'h0900, 1, 16'h08FA, 0, 0);
    {u_dec.mac, u_dec.mdec, u_dec.mstep} = 4'h0;
    // x buffer 0x1000..0x100F, sixteen bytes, pointer 2
    apb(1'b1, eag_pkg::REG_XSTART, 32'h0000_1000);
    apb(1'b1, eag_pkg::REG_XEND, 32'h0000_100F);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_80F2);
    rd_chk(eag_pkg::REG_XSTART, 32'h0000_1000, 1'b0);
    tx(eag_pkg::M_POST, 2'h0, 4'h2, 16'h100E, 16'h0002, 16'h100E, 1, 16'h1000, 1, 0);
    tx(eag_pkg::M_POST, 2'h1, 4'h2, 16'h100C, 16'h0006, 16'h100C, 1, 16'h1002, 1, 0);
    tx(eag_pkg::M_PRE, 2'h0, 4'h2, 16'h1000, 16'hFFFE, 16'h100E, 1, 16'h100E, 1, 0);
    tx(eag_pkg::M_IDX, 2'h0, 4'h2, 16'h100E, 16'h0004, 16'h1002, 0, 0, 1, 0);
    tx(eag_pkg::M_POST, 2'h0, 4'h3, 16'h100E, 16'h0002, 16'h100E, 1, 16'h1010, 0, 0);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_00F2);
    tx(eag_pkg::M_POST, 2'h0, 4'h2, 16'h100E, 16'h0002, 16'h100E, 1, 16'h1010, 0, 0);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_80FF);
    tx(eag_pkg::M_POST, 2'h0, 4'hF, 16'h100E, 16'h0002, 16'h100E, 1, 16'h1010, 0, 0);
    // y buffer 0x2000..0x201F, pointer 2, x left off
    apb(1'b1, eag_pkg::REG_YSTART, 32'h0000_2000);
    apb(1'b1, eag_pkg::REG_YEND, 32'h0000_201F);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_402F);
    tx(eag_pkg::M_POST, 2'h2, 4'h2, 16'h201E, 16'h0002, 16'h201E, 1, 16'h2000, 1, 0);
    tx(eag_pkg::M_IDX, 2'h2, 4'h2, 16'h2005, 16'h0000, 16'h2004, 0, 0, 0, 0);
    tx(eag_pkg::M_POST, 2'h0, 4'h2, 16'h201E, 16'h0002, 16'h201E, 1, 16'h2020, 0, 0);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_40FF);
    tx(eag_pkg::M_POST, 2'h2, 4'h2, 16'h201E, 16'h0002, 16'h201E, 1, 16'h2020, 0, 0);
    // full 64 Kbyte x buffer still wraps cleanly
    apb(1'b1, eag_pkg::REG_XSTART, 32'h0000_0000);
    apb(1'b1, eag_pkg::REG_XEND, 32'h0000_FFFF);
    apb(1'b1, eag_pkg::REG_CTRL, 32'h0000_80F2);
    u_dec.send(eag_pkg::M_PRE, 2'h0, 4'h2, 16'hFFFE, 16'h0004);
    chk_word("addr", 32'h0000_0002, 32'(addr));
    apb(1'b0, eag_pkg::REG_STATUS, 32'h0000_0000);
    chk_word("status_addr", 32'h0000_0002, 32'(rd[31:16]));
    print_verdict();
  end
endmodule
